// file: hw/fep_power_ctrl.sv
// Power-down controller for a modem front end: two pin-selected block
// masks, half-duplex fast power sequencing and a serial register port.
// Assumes pins arrive asynchronously, except the power-select pin.
`timescale 1ns/1ps

module fep_power_ctrl (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic power_select_pin_i,
  input wire logic transmit_burst_enable_pin_i,
  input wire logic receive_burst_enable_pin_i,
  input wire logic transmit_mute_pin_n_i,
  input wire logic transmit_word_clock_i,
  input wire logic mode_strap_i,
  input wire logic config_strap_i,
  input wire logic spi_clk_i,
  input wire logic spi_sel_n_i,
  input wire logic spi_data_i,
  output logic spi_data_o,
  output logic spi_data_oe_o,
  output logic [7:0] block_power_down_o,
  output logic line_driver_power_down_o,
  output logic transmit_converter_power_down_o,
  output logic interp_filter_disable_o,
  output logic interp_flush_midscale_o,
  output logic rx_clock_buffered_osc_o
);
  import fep_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0] transmit_burst_enable_pin_q;
    logic transmit_burst_enable_pin_d;
    logic [1:0] receive_burst_enable_pin_q;
    logic [1:0] mute_q;
    logic [1:0] tclk_q;
    logic tclk_d;
    logic [1:0] mode_q;
    logic [1:0] cfg_q;
    logic [1:0] sclk_q;
    logic sclk_d;
    logic [1:0] sel_q;
    logic [1:0] sdi_q;
    logic half_duplex;
    logic osc_buffered;
    logic [4:0] spi_cnt;
    logic [15:0] spi_shift;
    logic [7:0] spi_rd;
    logic spi_rd_dir;
    logic sdo;
    logic sdo_oe;
    logic [7:0] mask_low;
    logic [7:0] mask_high;
    logic [7:0] half_duplex_reg;
    fep_tx_state_t tx_st;
    logic [4:0] tx_cnt;
    logic [5:0] flush_cnt;
    logic [7:0] pd;
    logic driver_off;
    logic conv_off;
    logic filt_dis;
    logic flush;
  } fep_state_t;

  fep_state_t state_r;
  fep_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux; unmapped addresses read as zero

  function automatic logic [7:0] read_reg(input fep_state_t s,
                                          input logic [6:0] addr);
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      ADDR_MASK_PIN_LOW: d = s.mask_low;
      ADDR_MASK_PIN_HIGH: d = s.mask_high;
      ADDR_HALF_DUPLEX: d = s.half_duplex_reg;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic transmit_burst_enable_pin_rise;
    logic transmit_burst_enable_pin_fall;
    logic tclk_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [15:0] word;
    logic [4:0] delay;
    logic [7:0] mask;
    logic mute_fd;
    logic tx_fast;
    logic rx_fast;
    logic [7:0] fast_bits;

    state_nxt = state_r;
    transmit_burst_enable_pin_rise = state_r.transmit_burst_enable_pin_q[1] & ~state_r.transmit_burst_enable_pin_d;
    transmit_burst_enable_pin_fall = ~state_r.transmit_burst_enable_pin_q[1] & state_r.transmit_burst_enable_pin_d;
    tclk_rise = state_r.tclk_q[1] & ~state_r.tclk_d;
    sclk_rise = state_r.sclk_q[1] & ~state_r.sclk_d;
    sclk_fall = ~state_r.sclk_q[1] & state_r.sclk_d;
    word = {state_r.spi_shift[14:0], state_r.sdi_q[1]};
    delay = state_r.half_duplex_reg[HDX_DELAY_MSB:HDX_DELAY_LSB];
    mask = 8'h00;
    mute_fd = 1'b0;
    tx_fast = 1'b0;
    rx_fast = 1'b0;
    fast_bits = 8'h00;

    // Two-stage synchronisers; the second stage alone feeds logic
    state_nxt.transmit_burst_enable_pin_q = {state_r.transmit_burst_enable_pin_q[0], transmit_burst_enable_pin_i};
    state_nxt.transmit_burst_enable_pin_d = state_r.transmit_burst_enable_pin_q[1];
    state_nxt.receive_burst_enable_pin_q = {state_r.receive_burst_enable_pin_q[0], receive_burst_enable_pin_i};
    state_nxt.mute_q = {state_r.mute_q[0], transmit_mute_pin_n_i};
    state_nxt.tclk_q = {state_r.tclk_q[0], transmit_word_clock_i};
    state_nxt.tclk_d = state_r.tclk_q[1];
    state_nxt.mode_q = {state_r.mode_q[0], mode_strap_i};
    state_nxt.cfg_q = {state_r.cfg_q[0], config_strap_i};
    state_nxt.sclk_q = {state_r.sclk_q[0], spi_clk_i};
    state_nxt.sclk_d = state_r.sclk_q[1];
    state_nxt.sel_q = {state_r.sel_q[0], spi_sel_n_i};
    state_nxt.sdi_q = {state_r.sdi_q[0], spi_data_i};

    // Serial port: direction bit (1 = read), address, then data
    if (state_r.sel_q[1]) begin
      state_nxt.spi_cnt = 5'h00;
      state_nxt.sdo_oe = 1'b0;
    end else if (sclk_rise && state_r.spi_cnt != SPI_FRAME_BITS) begin
      state_nxt.spi_shift = word;
      state_nxt.spi_cnt = state_r.spi_cnt + 5'h01;
      // Direction is the first bit; it stays in the shifter and reaches word[15] as the frame ends
      if (state_r.spi_cnt == 5'h00) begin
        state_nxt.spi_rd_dir = state_r.sdi_q[1];
      end
      if (state_r.spi_cnt == SPI_FRAME_BITS - 5'h01 && !word[15]) begin
        case (word[14:8])
          ADDR_MASK_PIN_LOW: state_nxt.mask_low = word[7:0];
          ADDR_MASK_PIN_HIGH: state_nxt.mask_high = word[7:0];
          ADDR_HALF_DUPLEX: state_nxt.half_duplex_reg = word[7:0];
          default: state_nxt.spi_shift = word;
        endcase
      end
    end else if (sclk_fall && state_r.spi_rd_dir) begin
      if (state_r.spi_cnt == SPI_HEAD_BITS) begin
        state_nxt.spi_rd = read_reg(state_r, state_r.spi_shift[6:0]);
        state_nxt.sdo = state_nxt.spi_rd[7];
        state_nxt.sdo_oe = 1'b1;
      end else if (state_r.spi_cnt == SPI_FRAME_BITS) begin
        state_nxt.sdo_oe = 1'b0;
      end else if (state_r.spi_cnt > SPI_HEAD_BITS) begin
        state_nxt.spi_rd = {state_r.spi_rd[6:0], 1'b0};
        state_nxt.sdo = state_r.spi_rd[6];
      end
    end

    // Transmit-off sequencing, counted in transmit clock rising edges
    // Starts off after reset, so a strapped part idles until enable rises
    case (state_r.tx_st)
      FEP_TX_ON: begin
        if (transmit_burst_enable_pin_fall) begin
          state_nxt.tx_cnt = delay;
          state_nxt.tx_st = (delay == 5'h00)
                            ? FEP_TX_OFF
                            : FEP_TX_DELAY;
        end
      end
      FEP_TX_DELAY: begin
        if (transmit_burst_enable_pin_rise) begin
          state_nxt.tx_st = FEP_TX_ON;
        end else if (tclk_rise) begin
          state_nxt.tx_cnt = state_r.tx_cnt - 5'h01;
          if (state_r.tx_cnt == 5'h01) begin
            state_nxt.tx_st = FEP_TX_OFF;
          end
        end
      end
      FEP_TX_OFF: begin
        if (transmit_burst_enable_pin_rise) begin
          state_nxt.tx_st = FEP_TX_ON;
        end
      end
      default: state_nxt.tx_st = FEP_TX_ON;
    endcase

    // Midscale flush runs for FLUSH_TX_CYCLES transmit clock rising edges after enable falls
    // A stopped word clock freezes the count; the flush is then incomplete
    if (transmit_burst_enable_pin_rise) begin
      state_nxt.flush_cnt = 6'h00;
    end else if (transmit_burst_enable_pin_fall) begin
      state_nxt.flush_cnt = FLUSH_TX_CYCLES;
    end else if (tclk_rise && state_r.flush_cnt != 6'h00) begin
      state_nxt.flush_cnt = state_r.flush_cnt - 6'h01;
    end

    // Output composition
    // Power-select is registered once only, to keep the delay minimal;
    // the bus side must tolerate one cycle of possible metastability.
    mask = power_select_pin_i
           ? state_r.mask_high
           : state_r.mask_low;
    tx_fast = state_r.half_duplex
              & state_r.half_duplex_reg[HDX_FAST_TX_EN]
              & (state_r.tx_st == FEP_TX_OFF);
    // Receive steering follows the synced level, so either edge acts
    rx_fast = state_r.half_duplex
              & state_r.half_duplex_reg[HDX_FAST_RX_EN]
              & (state_r.half_duplex_reg[HDX_RX_SOURCE]
                 ? ~state_r.receive_burst_enable_pin_q[1]
                 : state_r.transmit_burst_enable_pin_q[1]);
    fast_bits[BIT_TX_DIGITAL] = tx_fast;
    fast_bits[BIT_RX_CONVERTER] = rx_fast;
    fast_bits[BIT_RX_AMP] = rx_fast;
    mute_fd = ~state_r.half_duplex & ~state_r.mute_q[1];
    state_nxt.pd = mask | fast_bits;
    state_nxt.driver_off = mask[BIT_CONV_DRIVER]
                           | tx_fast | mute_fd;
    state_nxt.conv_off = mask[BIT_CONV_DRIVER];
    state_nxt.filt_dis = mute_fd;
    state_nxt.flush = state_r.half_duplex
                      & state_r.half_duplex_reg[HDX_FAST_TX_EN]
                      & (state_r.flush_cnt != 6'h00);

    // Synchronous reset; straps are taken from the synchronisers,
    // so reset must be held for at least three clocks.
    if (reset_i) begin
      state_nxt.half_duplex = ~state_r.mode_q[1];
      state_nxt.osc_buffered = state_r.mode_q[1] & state_r.cfg_q[1];
      state_nxt.mask_low = RST_MASK_PIN_LOW;
      state_nxt.mask_high = (state_r.mode_q[1] & state_r.cfg_q[1])
                            ? RST_MASK_PIN_HIGH_ALL
                            : RST_MASK_PIN_HIGH;
      state_nxt.half_duplex_reg = RST_HALF_DUPLEX;
      state_nxt.spi_cnt = 5'h00;
      state_nxt.spi_shift = 16'h0000;
      state_nxt.spi_rd = 8'h00;
      state_nxt.spi_rd_dir = 1'b0;
      state_nxt.sdo = 1'b0;
      state_nxt.sdo_oe = 1'b0;
      state_nxt.tx_st = FEP_TX_OFF;
      state_nxt.tx_cnt = 5'h00;
      state_nxt.flush_cnt = 6'h00;
      state_nxt.pd = 8'h00;
      state_nxt.driver_off = 1'b0;
      state_nxt.conv_off = 1'b0;
      state_nxt.filt_dis = 1'b0;
      state_nxt.flush = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // One register holds every field; reset loads all of them except the synchroniser stages and the edge-detect delay stages

  always_ff @(posedge sys_clk_i) begin
    state_r <= state_nxt;
  end

  assign spi_data_o = state_r.sdo;
  assign spi_data_oe_o = state_r.sdo_oe;
  assign block_power_down_o = state_r.pd;
  assign line_driver_power_down_o = state_r.driver_off;
  assign transmit_converter_power_down_o = state_r.conv_off;
  assign interp_filter_disable_o = state_r.filt_dis;
  assign interp_flush_midscale_o = state_r.flush;
  assign rx_clock_buffered_osc_o = state_r.osc_buffered;

endmodule

// file: hw/fep_pkg.sv
// Constants for the front-end power-down controller.
// Assumes a single 200 MHz system clock and a serial register port.
package fep_pkg;

  // Register addresses on the serial port
  localparam logic [6:0] ADDR_MASK_PIN_LOW = 7'h01;
  localparam logic [6:0] ADDR_MASK_PIN_HIGH = 7'h02;
  localparam logic [6:0] ADDR_HALF_DUPLEX = 7'h03;

  // Block bit positions, same in both masks
  localparam int BIT_CLK_MULT = 7;
  localparam int BIT_CONV_DRIVER = 6;
  localparam int BIT_TX_DIGITAL = 5;
  localparam int BIT_REFERENCE = 4;
  localparam int BIT_CONV_CM_REF = 3;
  localparam int BIT_RX_CONVERTER = 2;
  localparam int BIT_GAIN_BIAS = 1;
  localparam int BIT_RX_AMP = 0;

  // Half-duplex register fields
  localparam int HDX_DELAY_MSB = 7;
  localparam int HDX_DELAY_LSB = 3;
  localparam int HDX_RX_SOURCE = 2;
  localparam int HDX_FAST_TX_EN = 1;
  localparam int HDX_FAST_RX_EN = 0;

  // Reset values
  localparam logic [7:0] RST_MASK_PIN_LOW = 8'h00;
  localparam logic [7:0] RST_MASK_PIN_HIGH = 8'h7F;
  localparam logic [7:0] RST_MASK_PIN_HIGH_ALL = 8'hFF;
  localparam logic [7:0] RST_HALF_DUPLEX = 8'hFB;

  // Transmit clock cycles of midscale flush after transmit enable falls
  localparam logic [5:0] FLUSH_TX_CYCLES = 6'h21;

  // Serial frame: 1 direction bit, 7 address bits, 8 data bits
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam logic [4:0] SPI_HEAD_BITS = 5'h08;

  typedef enum logic [1:0] {
    FEP_TX_ON = 2'b00,
    FEP_TX_DELAY = 2'b01,
    FEP_TX_OFF = 2'b11
  } fep_tx_state_t;

endpackage

// file: tb/fep_power_ctrl_asserts.sv
// Port checker for the front-end power-down controller.
// Bound into every fep_power_ctrl; sees its ports only.
`timescale 1ns/1ps
module fep_power_ctrl_asserts (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic power_select_pin_i,
  input wire logic transmit_burst_enable_pin_i,
  input wire logic receive_burst_enable_pin_i,
  input wire logic transmit_mute_pin_n_i,
  input wire logic transmit_word_clock_i,
  input wire logic spi_sel_n_i,
  input wire logic [7:0] block_power_down_o,
  input wire logic line_driver_power_down_o,
  input wire logic transmit_converter_power_down_o,
  input wire logic interp_filter_disable_o,
  input wire logic interp_flush_midscale_o,
  input wire logic rx_clock_buffered_osc_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Raw word-clock edges while flushing; one spare for sync skew
  logic wclk_d_r;
  logic [6:0] wclk_cnt_r;
  always_ff @(posedge sys_clk_i) begin
    wclk_d_r <= transmit_word_clock_i;
    if (reset_i || !interp_flush_midscale_o) begin
      wclk_cnt_r <= 7'h00;
    end else if (transmit_word_clock_i && !wclk_d_r) begin
      wclk_cnt_r <= wclk_cnt_r + 7'h01;
    end
  end
////////////////////////////////////////////////////////////////////////////
  a_conv_tracks_mask: assert property (
    transmit_converter_power_down_o == block_power_down_o[6])
    else $error("converter power differs from mask bit 6");
  a_driver_covers_conv: assert property (
    block_power_down_o[6] |-> line_driver_power_down_o)
    else $error("line driver on while bit 6 is down");
  a_mute_full_duplex: assert property (
    (rx_clock_buffered_osc_o && !transmit_mute_pin_n_i)[*6]
    |-> line_driver_power_down_o && interp_filter_disable_o)
    else $error("mute held low without driver off");
  a_filter_needs_mute: assert property (
    transmit_mute_pin_n_i[*6] |-> !interp_filter_disable_o)
    else $error("filter disabled with mute high");
  a_flush_cleared: assert property (
    transmit_burst_enable_pin_i[*6] |-> !interp_flush_midscale_o)
    else $error("flush running while enable held high");
  a_flush_bounded: assert property (
    wclk_cnt_r <= 7'h22)
    else $error("flush ran past its word-clock count");
  a_quiet_holds: assert property (
    (spi_sel_n_i && $stable(power_select_pin_i)
     && $stable(transmit_burst_enable_pin_i)
     && $stable(receive_burst_enable_pin_i)
     && $stable(transmit_mute_pin_n_i)
     && $stable(transmit_word_clock_i))[*8]
    |=> $stable(block_power_down_o))
    else $error("block power changed with inputs quiet");
  a_strap_clock_fixed: assert property (
    $changed(rx_clock_buffered_osc_o) |-> $past(reset_i)
    || $past(reset_i, 2))
    else $error("buffered clock select changed outside reset");
  c_flush: cover property (interp_flush_midscale_o);
  c_mute: cover property (interp_filter_disable_o);
  c_tx_off: cover property ($rose(line_driver_power_down_o));
endmodule
bind fep_power_ctrl fep_power_ctrl_asserts fep_power_ctrl_asserts_inst (.*);

// file: tb/fep_backend_model.sv
// Back-end model: serial register master and gated word clock.
// Assumes callers start a frame only after the last one returned.
`timescale 1ns/1ps
module fep_backend_model (
  input wire logic sys_clk_i,
  input wire logic word_clock_run_i,
  input wire logic miso_i,
  output logic spi_clk_o,
  output logic spi_sel_n_o,
  output logic mosi_o,
  output logic word_clock_o
);
  initial begin
    spi_clk_o = 1'b0;
    spi_sel_n_o = 1'b1;
    mosi_o = 1'b0;
    word_clock_o = 1'b0;
  end
  // 20 MHz word clock; stops between bursts, as a real back end may
  always begin
    repeat (5) @(posedge sys_clk_i);
    if (word_clock_run_i) word_clock_o <= ~word_clock_o;
  end
  // Phases of 5 cycles stay above the 4-cycle minimum
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] f;
    f = {rd, a, wd};
    rdat = 8'h00;
    @(posedge sys_clk_i);
    spi_sel_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o <= f[i];
      spi_clk_o <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      if (i < 8) rdat[i] = miso_i;
      spi_clk_o <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
    end
    spi_clk_o <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    spi_sel_n_o <= 1'b1;
    mosi_o <= ~f[0];
    repeat (5) @(posedge sys_clk_i);
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the front-end power-down controller.
// Assumes the back-end model and the port checker compile before it.
`timescale 1ns/1ps
module tb_top;
  import fep_pkg::*;
  logic sys_clk_i, reset_i, power_select_pin_i, mode_strap_i;
  logic transmit_burst_enable_pin_i, receive_burst_enable_pin_i;
  logic transmit_mute_pin_n_i, transmit_word_clock_i, config_strap_i;
  logic spi_clk_i, spi_sel_n_i, spi_data_i, spi_data_o, spi_data_oe_o;
  logic line_driver_power_down_o, transmit_converter_power_down_o;
  logic interp_filter_disable_o, interp_flush_midscale_o;
  logic rx_clock_buffered_osc_o, word_clock_run;
  logic [7:0] block_power_down_o;
  int n_fail, checks_done, cyc;
  fep_power_ctrl fep_power_ctrl_inst (.*);
  fep_backend_model fep_backend_model_inst (
    .sys_clk_i(sys_clk_i), .word_clock_run_i(word_clock_run),
    .miso_i(spi_data_o), .spi_clk_o(spi_clk_i),
    .spi_sel_n_o(spi_sel_n_i), .mosi_o(spi_data_i),
    .word_clock_o(transmit_word_clock_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The run needs about 3200 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input string w, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic cb(input logic [7:0] e);
    chk("block", block_power_down_o, e);
  endtask
  task automatic cd(input logic e);
    chk("driver", {7'h00, line_driver_power_down_o}, {7'h00, e});
  endtask
  task automatic cf(input logic e);
    chk("flush", {7'h00, interp_flush_midscale_o}, {7'h00, e});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    fep_backend_model_inst.xfer(1'b0, a, d, v);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    fep_backend_model_inst.xfer(1'b1, a, 8'h00, v);
    chk($sformatf("register %h", a), v, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic do_reset(input logic m, input logic c);
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    mode_strap_i <= m;
    config_strap_i <= c;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    tick(4);
  endtask
  initial begin
    {sys_clk_i, power_select_pin_i, word_clock_run} = 3'h0;
    {transmit_burst_enable_pin_i, receive_burst_enable_pin_i} = 2'h0;
    {reset_i, transmit_mute_pin_n_i} = 2'h3;
    do_reset(1'b0, 1'b0);
    rd(ADDR_MASK_PIN_LOW, 8'h00);
    rd(ADDR_MASK_PIN_HIGH, 8'h7F);
    rd(ADDR_HALF_DUPLEX, 8'hFB);
    chk("data enable", {7'h00, spi_data_oe_o}, 8'h00);
    wr(7'h05, 8'hAA);
    rd(7'h05, 8'h00);
    wr(ADDR_HALF_DUPLEX, 8'h00);
    wr(ADDR_MASK_PIN_LOW, 8'h60);
    wr(ADDR_MASK_PIN_HIGH, 8'h05);
    tick(1);
    cb(8'h60);
    cd(1'b1);
    @(posedge sys_clk_i) power_select_pin_i <= 1'b1;
    tick(1);
    cb(8'h05);
    @(posedge sys_clk_i) power_select_pin_i <= 1'b0;
    wr(ADDR_MASK_PIN_LOW, 8'h00);
    wr(ADDR_HALF_DUPLEX, 8'h13);
    tick(1);
    cb(8'h20);
    @(posedge sys_clk_i) transmit_burst_enable_pin_i <= 1'b1;
    tick(5);
    cb(8'h05);
    cd(1'b0);
    @(posedge sys_clk_i) begin
      transmit_burst_enable_pin_i <= 1'b0;
      word_clock_run <= 1'b1;
    end
    tick(5);
    cf(1'b1);
    cd(1'b0);
    tick(40);
    cb(8'h20);
    cd(1'b1);
    chk("converter", {7'h00, transmit_converter_power_down_o}, 8'h00);
    tick(250);
    cf(1'b1);
    tick(70);
    cf(1'b0);
    wr(ADDR_HALF_DUPLEX, 8'hFB);
    @(posedge sys_clk_i) transmit_burst_enable_pin_i <= 1'b1;
    tick(8);
    @(posedge sys_clk_i) transmit_burst_enable_pin_i <= 1'b0;
    tick(100);
    @(posedge sys_clk_i) transmit_burst_enable_pin_i <= 1'b1;
    tick(400);
    cd(1'b0);
    @(posedge sys_clk_i) word_clock_run <= 1'b0;
    wr(ADDR_HALF_DUPLEX, 8'h17);
    tick(1);
    cb(8'h05);
    @(posedge sys_clk_i) receive_burst_enable_pin_i <= 1'b1;
    tick(5);
    cb(8'h00);
    @(posedge sys_clk_i) power_select_pin_i <= 1'b1;
    tick(1);
    cb(8'h05);
    do_reset(1'b1, 1'b1);
    chk("osc", {7'h00, rx_clock_buffered_osc_o}, 8'h01);
    cb(8'hFF);
    rd(ADDR_MASK_PIN_HIGH, 8'hFF);
    @(posedge sys_clk_i) power_select_pin_i <= 1'b0;
    @(posedge sys_clk_i) transmit_burst_enable_pin_i <= 1'b0;
    tick(8);
    cb(8'h00);
    @(posedge sys_clk_i) transmit_mute_pin_n_i <= 1'b0;
    tick(5);
    cd(1'b1);
    chk("filter", {7'h00, interp_filter_disable_o}, 8'h01);
    tally_and_finish();
  end
endmodule
